// file: logic/fws_pkg.sv
// constants for the parallel flash sequencer: register map, fields, timing
// assumes a 10 MHz system clock; all pin timing is counted in whole cycles
package fws_pkg;

    // ==========================================================
    // clock and pin widths
    localparam int unsigned CLK_NS = 100;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned NS_PER_S = 1000000000;
    localparam int unsigned FL_ADDR_W = 22;
    localparam int unsigned FL_DATA_W = 16;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned CNT_W = 8;

    // ==========================================================
    // pin timing, least times round up
    localparam int unsigned T_WP_NS = 60;
    localparam int unsigned T_WPH_NS = 30;
    localparam int unsigned T_WR_RD_NS = 30;
    localparam int unsigned T_AS_NS = 10;
    localparam int unsigned T_PWH_NS = 30;
    localparam int unsigned T_ACC_NS = 90;
    localparam int unsigned T_BFD_EXTRA_NS = 50;
    localparam int unsigned T_BFD_QRY_EXTRA_NS = 100;
    localparam int unsigned WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WPH_CYC = (T_WPH_NS + T_WR_RD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned AS_CYC = (T_AS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PWH_CYC = (T_PWH_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned BFD_CYC = (T_ACC_NS + T_BFD_EXTRA_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned BFD_QRY_CYC = (T_ACC_NS + T_BFD_QRY_EXTRA_NS + CLK_NS - 1) / CLK_NS;

    // ==========================================================
    // completion limits, longest times round down
    localparam int unsigned PRG_SUSP_US = 10;
    localparam int unsigned ERS_SUSP_US = 20;
    localparam int unsigned ERES_US = 500;
    localparam int unsigned ERASE_PARAM_S = 4;
    localparam int unsigned ERASE_MAIN_S = 5;
    localparam int unsigned PRG_SUSP_CYC = PRG_SUSP_US * NS_PER_US / CLK_NS;
    localparam int unsigned ERS_SUSP_CYC = ERS_SUSP_US * NS_PER_US / CLK_NS;
    localparam int unsigned ERES_CYC = ERES_US * NS_PER_US / CLK_NS;
    localparam int unsigned ERASE_PARAM_CYC = ERASE_PARAM_S * (NS_PER_S / CLK_NS);
    localparam int unsigned ERASE_MAIN_CYC = ERASE_MAIN_S * (NS_PER_S / CLK_NS);

    // ==========================================================
    // register map, byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_RDATA = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [2:0] IDX_CMD = 3'h0;
    localparam logic [2:0] IDX_ADDR = 3'h1;
    localparam logic [2:0] IDX_WDATA = 3'h2;
    localparam logic [2:0] IDX_RDATA = 3'h3;
    localparam logic [2:0] IDX_STAT = 3'h4;
    localparam logic [2:0] IDX_NONE = 3'h7;

    // ==========================================================
    // command register fields
    localparam int unsigned CMD_OP_LO = 0;
    localparam int unsigned CMD_BANK = 2;
    localparam int unsigned CMD_OTP = 3;
    localparam int unsigned CMD_SUSP = 4;
    localparam int unsigned CMD_RESUME = 5;
    localparam int unsigned CMD_QRY = 6;
    localparam int unsigned CMD_GLOBAL = 7;
    localparam int unsigned CMD_TMO_LO = 8;
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_POLL = 2'h2;
    localparam logic [1:0] TMO_MAIN = 2'h0;
    localparam logic [1:0] TMO_PARAM = 2'h1;
    localparam logic [1:0] TMO_ERS_SUSP = 2'h2;
    localparam logic [1:0] TMO_PRG_SUSP = 2'h3;
    localparam logic [15:0] CMD_RST = 16'h0000;

    // ==========================================================
    // status word bits, flash status bits
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_READY = 1;
    localparam int unsigned ST_REF_OTP = 2;
    localparam int unsigned ST_REF_SUSP = 3;
    localparam int unsigned ST_TMO = 4;
    localparam int unsigned ST_RES_OPEN = 5;
    localparam int unsigned SR_PART_RDY = 7;
    localparam int unsigned SR_GLOB_RDY = 15;
    localparam logic [15:0] SR_DETAIL_MASK = 16'hff81;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // pin sequencer states, gray from FWS_IDLE through FWS_GAP
    typedef enum logic [2:0] {
        FWS_IDLE = 3'h0,
        FWS_SETUP = 3'h1,
        FWS_ACT = 3'h3,
        FWS_HOLD = 3'h2,
        FWS_GAP = 3'h6
    } fws_state_t;

endpackage

// file: logic/fws_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none

module fws_sync #(
    parameter int unsigned W = 16
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [W-1:0] meta_ff;
        logic [W-1:0] sync_ff;
    } fws_sync_t;

    fws_sync_t s_ff;
    fws_sync_t nxt_s;

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.meta_ff = d;
        nxt_s.sync_ff = s_ff.meta_ff;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            s_ff <= '0;
        else if (ce)
            s_ff <= nxt_s;
    end

    assign q = s_ff.sync_ff;

endmodule

`default_nettype wire

// file: logic/fws_ctrl.sv
// host sequencer for an asynchronous parallel flash with per-partition status
// assumes an AXI4-Lite master on sys_clk; flash pins are asynchronous
`timescale 1ns/100ps
`default_nettype none

module fws_ctrl
    import fws_pkg::*;
#(
    parameter int unsigned RESUME_CYC = fws_pkg::ERES_CYC,
    parameter int unsigned ERASE_MAIN_TMO = fws_pkg::ERASE_MAIN_CYC,
    parameter int unsigned ERASE_PARAM_TMO = fws_pkg::ERASE_PARAM_CYC
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // axi4-lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // flash pins
    output logic [fws_pkg::FL_ADDR_W-1:0] fl_addr,
    output logic bank_select_0_n,
    output logic bank_select_1_n,
    output logic fl_we_n,
    output logic fl_oe_n,
    input wire logic [fws_pkg::FL_DATA_W-1:0] fl_dq_in,
    output logic [fws_pkg::FL_DATA_W-1:0] fl_dq_out,
    output logic fl_dq_oe
);

    // ==========================================================
    // state
    typedef struct packed {
        fws_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] bfd_cnt;
        logic [31:0] res_cnt;
        logic [31:0] tmo_cnt;
        logic [15:0] cmd;
        logic [FL_ADDR_W-1:0] addr;
        logic [FL_DATA_W-1:0] wdat;
        logic [FL_DATA_W-1:0] rdat;
        logic ready;
        logic ref_otp;
        logic ref_susp;
        logic tmo;
        logic aw_held;
        logic [7:0] aw_q;
        logic w_held;
        logic [31:0] w_q;
        logic [3:0] ws_q;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
        logic [FL_ADDR_W-1:0] p_addr;
        logic [1:0] p_bank_n;
        logic p_we_n;
        logic p_oe_n;
        logic [FL_DATA_W-1:0] p_dq;
        logic p_dq_oe;
    } fws_ctrl_t;

    localparam fws_ctrl_t RST_S = '{st: FWS_IDLE, cmd: CMD_RST, p_bank_n: 2'h3, p_we_n: 1'b1,
                                    p_oe_n: 1'b1, default: '0};

    fws_ctrl_t s_ff;
    fws_ctrl_t nxt_s;
    logic [FL_DATA_W-1:0] dq_sync;

    // ==========================================================
    // helpers
    function automatic logic [2:0] reg_idx(input logic [7:0] a);
        case (a)
            OFS_CMD: reg_idx = IDX_CMD;
            OFS_ADDR: reg_idx = IDX_ADDR;
            OFS_WDATA: reg_idx = IDX_WDATA;
            OFS_RDATA: reg_idx = IDX_RDATA;
            OFS_STAT: reg_idx = IDX_STAT;
            default: reg_idx = IDX_NONE;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    fws_sync #(.W(FL_DATA_W)) u_dq_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .d(fl_dq_in),
        .q(dq_sync)
    );

    // ==========================================================
    // next state
    always_comb
    begin
        logic [31:0] mw;
        logic [15:0] c;
        logic [1:0] op;
        logic [1:0] c_op;
        logic busy;
        logic rdy_bit;
        mw = '0;
        c = s_ff.cmd;
        op = s_ff.cmd[CMD_OP_LO +: 2];
        c_op = '0;
        busy = (s_ff.st != FWS_IDLE);
        rdy_bit = s_ff.cmd[CMD_GLOBAL] ? s_ff.rdat[SR_GLOB_RDY] : s_ff.rdat[SR_PART_RDY];
        nxt_s = s_ff;
        if (s_ff.res_cnt != '0)
            nxt_s.res_cnt = s_ff.res_cnt - 32'h1;
        if (s_ff.bfd_cnt != '0)
            nxt_s.bfd_cnt = s_ff.bfd_cnt - 8'h1;
        if (busy && s_ff.tmo_cnt != '0)
            nxt_s.tmo_cnt = s_ff.tmo_cnt - 32'h1;

        // axi write side
        if (awvalid && !s_ff.aw_held && !s_ff.bv)
        begin
            nxt_s.aw_held = 1'b1;
            nxt_s.aw_q = awaddr;
        end
        if (wvalid && !s_ff.w_held && !s_ff.bv)
        begin
            nxt_s.w_held = 1'b1;
            nxt_s.w_q = wdata;
            nxt_s.ws_q = wstrb;
        end
        if (s_ff.bv && bready)
            nxt_s.bv = 1'b0;
        if (s_ff.aw_held && s_ff.w_held && !s_ff.bv)
        begin
            nxt_s.aw_held = 1'b0;
            nxt_s.w_held = 1'b0;
            nxt_s.bv = 1'b1;
            nxt_s.br = RESP_OKAY;
            case (reg_idx(s_ff.aw_q))
                IDX_ADDR:
                begin
                    mw = merge({10'h0, s_ff.addr}, s_ff.w_q, s_ff.ws_q);
                    if (busy)
                        nxt_s.br = RESP_SLVERR;
                    else
                        nxt_s.addr = mw[FL_ADDR_W-1:0];
                end
                IDX_WDATA:
                begin
                    mw = merge({16'h0, s_ff.wdat}, s_ff.w_q, s_ff.ws_q);
                    if (busy)
                        nxt_s.br = RESP_SLVERR;
                    else
                        nxt_s.wdat = mw[FL_DATA_W-1:0];
                end
                IDX_CMD:
                begin
                    mw = merge({16'h0, s_ff.cmd}, s_ff.w_q, s_ff.ws_q);
                    c = mw[15:0];
                    c_op = c[CMD_OP_LO +: 2];
                    if (busy)
                        nxt_s.br = RESP_SLVERR;
                    else if (c_op == OP_WRITE && c[CMD_OTP] && c[CMD_BANK])
                        nxt_s.ref_otp = 1'b1;
                    else if (c_op == OP_WRITE && c[CMD_SUSP] && s_ff.res_cnt != '0)
                        nxt_s.ref_susp = 1'b1;
                    else
                    begin
                        nxt_s.cmd = c;
                        nxt_s.st = FWS_SETUP;
                        nxt_s.cnt = CNT_W'(AS_CYC);
                        nxt_s.ready = 1'b0;
                        nxt_s.ref_otp = 1'b0;
                        nxt_s.ref_susp = 1'b0;
                        nxt_s.tmo = 1'b0;
                        case (c[CMD_TMO_LO +: 2])
                            TMO_PARAM: nxt_s.tmo_cnt = ERASE_PARAM_TMO;
                            TMO_ERS_SUSP: nxt_s.tmo_cnt = ERS_SUSP_CYC;
                            TMO_PRG_SUSP: nxt_s.tmo_cnt = PRG_SUSP_CYC;
                            default: nxt_s.tmo_cnt = ERASE_MAIN_TMO;
                        endcase
                        if (c_op == OP_WRITE && c[CMD_RESUME])
                            nxt_s.res_cnt = RESUME_CYC;
                    end
                end
                default: nxt_s.br = RESP_SLVERR;
            endcase
        end

        // axi read side
        if (s_ff.rv && rready)
            nxt_s.rv = 1'b0;
        if (arvalid && !s_ff.rv)
        begin
            nxt_s.rv = 1'b1;
            nxt_s.rr = RESP_OKAY;
            case (reg_idx(araddr))
                IDX_CMD: nxt_s.rd = {16'h0, s_ff.cmd};
                IDX_ADDR: nxt_s.rd = {10'h0, s_ff.addr};
                IDX_WDATA: nxt_s.rd = {16'h0, s_ff.wdat};
                IDX_RDATA: nxt_s.rd = {16'h0, s_ff.rdat};
                IDX_STAT: nxt_s.rd = {26'h0, (s_ff.res_cnt != '0), s_ff.tmo, s_ff.ref_susp,
                                      s_ff.ref_otp, s_ff.ready, busy};
                default:
                begin
                    nxt_s.rd = '0;
                    nxt_s.rr = RESP_SLVERR;
                end
            endcase
        end

        // pin sequencer
        case (s_ff.st)
            FWS_IDLE:
            begin
                nxt_s.p_bank_n = 2'h3;
                nxt_s.p_we_n = 1'b1;
                nxt_s.p_oe_n = 1'b1;
                nxt_s.p_dq_oe = 1'b0;
            end
            FWS_SETUP:
            begin
                nxt_s.p_addr = s_ff.addr;
                nxt_s.p_bank_n = s_ff.cmd[CMD_BANK] ? 2'h1 : 2'h2;
                nxt_s.p_dq = s_ff.wdat;
                nxt_s.p_dq_oe = (op == OP_WRITE);
                if (s_ff.cnt != '0)
                    nxt_s.cnt = s_ff.cnt - 8'h1;
                else if (op != OP_WRITE && s_ff.bfd_cnt != '0)
                    nxt_s.cnt = '0;
                else
                begin
                    nxt_s.st = FWS_ACT;
                    if (op == OP_WRITE)
                    begin
                        nxt_s.p_we_n = 1'b0;
                        nxt_s.cnt = CNT_W'(WP_CYC - 1);
                    end
                    else
                    begin
                        nxt_s.p_oe_n = 1'b0;
                        nxt_s.cnt = CNT_W'(ACC_CYC + SYNC_STAGES - 1);
                    end
                end
            end
            FWS_ACT:
            begin
                if (s_ff.cnt != '0)
                    nxt_s.cnt = s_ff.cnt - 8'h1;
                else
                begin
                    nxt_s.st = FWS_HOLD;
                    nxt_s.p_we_n = 1'b1;
                    nxt_s.p_oe_n = 1'b1;
                    if (op != OP_WRITE)
                        nxt_s.rdat = dq_sync[SR_PART_RDY] ? dq_sync : (dq_sync & SR_DETAIL_MASK);
                end
            end
            FWS_HOLD:
            begin
                nxt_s.st = FWS_GAP;
                nxt_s.p_bank_n = 2'h3;
                nxt_s.cnt = CNT_W'((op == OP_WRITE) ? WPH_CYC - 1 : PWH_CYC - 1);
                if (op == OP_WRITE)
                    nxt_s.bfd_cnt = CNT_W'(s_ff.cmd[CMD_QRY] ? BFD_QRY_CYC : BFD_CYC);
            end
            FWS_GAP:
            begin
                nxt_s.p_dq_oe = 1'b0;
                if (s_ff.cnt != '0)
                    nxt_s.cnt = s_ff.cnt - 8'h1;
                else if (op != OP_POLL)
                    nxt_s.st = FWS_IDLE;
                else if (rdy_bit)
                begin
                    nxt_s.st = FWS_IDLE;
                    nxt_s.ready = 1'b1;
                end
                else if (s_ff.tmo_cnt == '0)
                begin
                    nxt_s.st = FWS_IDLE;
                    nxt_s.tmo = 1'b1;
                end
                else
                begin
                    nxt_s.st = FWS_SETUP;
                    nxt_s.cnt = CNT_W'(AS_CYC);
                end
            end
            default: nxt_s.st = FWS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            s_ff <= RST_S;
        else if (ce)
            s_ff <= nxt_s;
    end

    // ==========================================================
    // outputs
    assign awready = ce && !s_ff.aw_held && !s_ff.bv;
    assign wready = ce && !s_ff.w_held && !s_ff.bv;
    assign bvalid = s_ff.bv;
    assign bresp = s_ff.br;
    assign arready = ce && !s_ff.rv;
    assign rvalid = s_ff.rv;
    assign rdata = s_ff.rd;
    assign rresp = s_ff.rr;
    assign fl_addr = s_ff.p_addr;
    assign bank_select_0_n = s_ff.p_bank_n[0];
    assign bank_select_1_n = s_ff.p_bank_n[1];
    assign fl_we_n = s_ff.p_we_n;
    assign fl_oe_n = s_ff.p_oe_n;
    assign fl_dq_out = s_ff.p_dq;
    assign fl_dq_oe = s_ff.p_dq_oe;

endmodule

`default_nettype wire

// file: verification/fws_ctrl_assertions.sv
// pin timing checker for the flash sequencer
// assumes a bind into fws_ctrl, single clock domain
`timescale 1ns/100ps
`default_nettype none
module fws_chk
    import fws_pkg::*;
(
    // clock, reset
    input wire logic sys_clk,
    input wire logic rst,
    // flash pins
    input wire logic [fws_pkg::FL_ADDR_W-1:0] fl_addr,
    input wire logic bank_select_0_n,
    input wire logic bank_select_1_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    input wire logic fl_dq_oe
);
    wire logic bank_on = !bank_select_0_n || !bank_select_1_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========
    // write and read strobes
    we_in_frame_a: assert property (!fl_we_n |-> bank_on && fl_dq_oe && fl_oe_n)
        else $error("write strobe outside frame");
    we_pulse_a: assert property ($fell(fl_we_n) |=> $rose(fl_we_n))
        else $error("write pulse length");
    we_release_a: assert property ($rose(fl_we_n) |-> bank_on && fl_dq_oe ##1 !bank_on)
        else $error("write release order");
    busy_wait_a: assert property ($rose(fl_we_n) |-> fl_oe_n [*3])
        else $error("read too soon after write");
    rd_clean_a: assert property (!fl_oe_n |-> fl_we_n && !fl_dq_oe && bank_on)
        else $error("read strobe clash");
    rd_pulse_a: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*3] ##1 fl_oe_n)
        else $error("read pulse length");
    addr_setup_a: assert property ($fell(fl_oe_n) |-> $stable(fl_addr) && $past(bank_on))
        else $error("status address setup");
    addr_hold_a: assert property (!fl_oe_n |=> $stable(fl_addr))
        else $error("status address hold");
    rd_gap_a: assert property ($rose(fl_oe_n) |-> bank_on ##1 fl_oe_n && !bank_on)
        else $error("status read gap");
    one_bank_a: assert property (bank_select_0_n || bank_select_1_n)
        else $error("both banks enabled");
    cover property ($rose(fl_we_n) && !bank_select_1_n);
    cover property ($rose(fl_oe_n));
    cover property ($fell(fl_oe_n) ##[1:20] $fell(fl_oe_n));
endmodule
bind fws_ctrl fws_chk u_chk (.sys_clk(sys_clk), .rst(rst), .fl_addr(fl_addr), .bank_select_0_n(bank_select_0_n),
    .bank_select_1_n(bank_select_1_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_oe(fl_dq_oe));
`default_nettype wire

// file: verification/fws_flash_model.sv
// flash device model: two partitions, status word reads, timed busy
// assumes the pins of fws_ctrl; counts busy on sys_clk
`timescale 1ns/100ps
`default_nettype none
module fws_flash_model
    import fws_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // host pins
    input wire logic [fws_pkg::FL_ADDR_W-1:0] fl_addr,
    input wire logic bank_select_0_n,
    input wire logic bank_select_1_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    input wire logic [fws_pkg::FL_DATA_W-1:0] fl_dq_out,
    output logic [fws_pkg::FL_DATA_W-1:0] fl_dq_in
);
    int busy[2] = '{0, 0};
    wire logic sel = !bank_select_0_n || !bank_select_1_n;
    initial fl_dq_in = 16'h0000;
    // ==========
    // command taken at end of write strobe
    always @(posedge fl_we_n)
    begin
        if (sel && fl_dq_out[15])
            busy[fl_addr[21]] = int'(fl_dq_out[11:0]);
        else if (sel && fl_dq_out == 16'h00b0 && busy[fl_addr[21]] > 8)
            busy[fl_addr[21]] = 8;
    end
    // operations count down to ready
    always @(posedge sys_clk)
    begin
        for (int i = 0; i < 2; i++)
            if (busy[i] > 0)
                busy[i] = busy[i] - 1;
    end
    // status word out, released bus toggles
    always @(negedge sys_clk)
    begin
        if (sel && !fl_oe_n)
            fl_dq_in <= {busy[0] == 0 && busy[1] == 0, 7'h00, busy[fl_addr[21]] == 0, 7'h54};
        else
            fl_dq_in <= ~fl_dq_in;
    end
endmodule
`default_nettype wire

// file: verification/fws_ctrl_tb.sv
// self-checking bench for the flash sequencer with a device model
// assumes fws_pkg, fws_ctrl, fws_flash_model and the checker bind
`timescale 1ns/100ps
`default_nettype none
module fws_ctrl_tb;
    import fws_pkg::*;
    localparam logic [21:0] P1 = 22'h200000;
    logic sys_clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic ce = 1'b1, bready = 1'b0, rready = 1'b0;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, v;
    logic [1:0] r;
    wire logic awready, wready, bvalid, arready, rvalid, fl_we_n, fl_oe_n, fl_dq_oe, bs0_n, bs1_n;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [21:0] fl_addr;
    wire logic [15:0] fl_dq_in, fl_dq_out;
    int n_mismatch = 0, checks = 0, seed = 32'hba5e;
    always #50 sys_clk = ~sys_clk;
    fws_ctrl #(.RESUME_CYC(20), .ERASE_MAIN_TMO(400), .ERASE_PARAM_TMO(200)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .fl_addr(fl_addr), .bank_select_0_n(bs0_n), .bank_select_1_n(bs1_n),
        .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe));
    fws_flash_model u_mem (.sys_clk(sys_clk), .fl_addr(fl_addr), .bank_select_0_n(bs0_n), .bank_select_1_n(bs1_n),
        .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_out(fl_dq_out), .fl_dq_in(fl_dq_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_on, w_on;
        aw_on = 1'b1;
        w_on = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw_on || w_on)
        begin
            @(posedge sys_clk);
            if (aw_on && awready === 1'b1)
            begin
                aw_on = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_on && wready === 1'b1)
            begin
                w_on = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        wr(a, d, r);
        chk(r, er);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        rd(a, v, r);
        chk(v, e);
        chk(r, er);
    endtask
    task automatic idle_stat(input logic [31:0] e);
        int i;
        i = 0;
        rd(OFS_STAT, v, r);
        while (v[ST_BUSY] !== 1'b0 && i < 400)
        begin
            rd(OFS_STAT, v, r);
            i++;
        end
        chk(v, e);
    endtask
    task automatic op(input logic [21:0] a, input logic [15:0] d, input logic [15:0] c, input logic [31:0] e);
        wrc(OFS_ADDR, {10'h0, a}, RESP_OKAY);
        wrc(OFS_WDATA, {16'h0, d}, RESP_OKAY);
        wrc(OFS_CMD, {16'h0, c}, RESP_OKAY);
        idle_stat(e);
    endtask
    function automatic logic [31:0] sw(input logic g, input logic p);
        return {16'h0, g, 7'h00, p, p ? 7'h54 : 7'h00};
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #(100 * 40000);
        n_mismatch++;
        give_verdict();
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        for (int k = 0; k < 5; k++)
            rdc(8'(k * 4), 32'h0, RESP_OKAY);
        rdc(8'h14, 32'h0, RESP_SLVERR);
        wrc(OFS_STAT, 32'h1, RESP_SLVERR);
        ce <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({30'h0, arready, awready}, 32'h0);
        ce <= 1'b1;
        $display("test 1 done");
        repeat (3)
        begin
            v = $random(seed);
            wrc(OFS_ADDR, v, RESP_OKAY);
            rdc(OFS_ADDR, {10'h0, v[21:0]}, RESP_OKAY);
            wrc(OFS_WDATA, v, RESP_OKAY);
            rdc(OFS_WDATA, {16'h0, v[15:0]}, RESP_OKAY);
        end
        wstrb <= 4'h1;
        wrc(OFS_WDATA, 32'ha5, RESP_OKAY);
        wstrb <= 4'hf;
        rdc(OFS_WDATA, {16'h0, v[15:8], 8'ha5}, RESP_OKAY);
        $display("test 2 done");
        wrc(OFS_ADDR, {10'h0, P1}, RESP_OKAY);
        wrc(OFS_WDATA, 32'h8064, RESP_OKAY);
        wrc(OFS_CMD, 32'h0, RESP_OKAY);
        wrc(OFS_ADDR, 32'h0, RESP_SLVERR);
        idle_stat(32'h0);
        rdc(OFS_ADDR, {10'h0, P1}, RESP_OKAY);
        $display("test 3 done");
        op(22'h0, 16'h0, {6'h0, TMO_MAIN, 6'h00, OP_POLL}, 32'h2);
        rdc(OFS_RDATA, sw(1'b0, 1'b1), RESP_OKAY);
        op(P1, 16'h0, {6'h0, TMO_MAIN, 6'h00, OP_POLL}, 32'h2);
        rdc(OFS_RDATA, sw(1'b1, 1'b1), RESP_OKAY);
        op(P1, 16'h8064, {6'h0, TMO_MAIN, 6'h10, OP_WRITE}, 32'h0);
        op(22'h0, 16'h0, {6'h0, TMO_MAIN, 6'h20, OP_POLL}, 32'h2);
        rdc(OFS_RDATA, sw(1'b1, 1'b1), RESP_OKAY);
        $display("test 4 done");
        op(P1, 16'h8fa0, 16'h0, 32'h0);
        op(P1, 16'h0, {6'h0, TMO_MAIN, 6'h00, OP_READ}, 32'h0);
        rdc(OFS_RDATA, sw(1'b0, 1'b0), RESP_OKAY);
        op(P1, 16'h0, {6'h0, TMO_PARAM, 6'h00, OP_POLL}, 32'h10);
        $display("test 5 done");
        for (int k = 0; k < 2; k++)
        begin
            op(P1, 16'h8fa0, 16'h0, 32'h0);
            op(P1, 16'h00b0, k ? 16'h0010 : 16'h0000, 32'h0);
            op(P1, 16'h0, {6'h0, k ? TMO_ERS_SUSP : TMO_PRG_SUSP, 6'h00, OP_POLL}, 32'h2);
        end
        $display("test 6 done");
        wrc(OFS_CMD, 32'h20, RESP_OKAY);
        r = RESP_SLVERR;
        for (int k = 0; k < 20 && r !== RESP_OKAY; k++)
            wr(OFS_CMD, 32'h10, r);
        idle_stat(32'h28);
        repeat (30) @(posedge sys_clk);
        wrc(OFS_CMD, 32'h10, RESP_OKAY);
        idle_stat(32'h0);
        $display("test 7 done");
        wrc(OFS_CMD, 32'h0c, RESP_OKAY);
        idle_stat(32'h4);
        wrc(OFS_CMD, 32'h08, RESP_OKAY);
        idle_stat(32'h0);
        wrc(OFS_CMD, 32'h04, RESP_OKAY);
        idle_stat(32'h0);
        $display("test 8 done");
        give_verdict();
    end
endmodule
`default_nettype wire
